/* core/txmc_pkg.sv */
/*
 * Shared constants and types for the transmitter mode-control register bank:
 * frame layout, register addresses, power-up values, field positions, states.
 * Assumes a 24-bit serial frame: 20 data bits then a 4-bit address, MSB first.
 */
package txmc_pkg;

    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS  = 4;
    localparam int REG_BITS   = 16;
    localparam int ADDR_LSB   = 0;
    localparam int DATA_LSB   = 4;

    localparam logic [3:0]  ADDR_OP   = 4'h4;
    localparam logic [3:0]  ADDR_CFG  = 4'h5;
    localparam logic [15:0] OP_RESET  = 16'h892F;
    localparam logic [15:0] CFG_RESET = 16'hD03F;

    // operation_control field positions
    localparam int OP_LO_PORT_SELECT   = 15;
    localparam int OP_BOOST    = 13;
    localparam int OP_BAND_HI  = 12;
    localparam int OP_BAND_LO  = 11;
    localparam int OP_GAIN_HI  = 8;
    localparam int OP_GAIN_LO  = 6;
    localparam int OP_SIDEBAND = 5;
    localparam int OP_BUF      = 4;
    localparam int OP_MOD      = 3;
    localparam int OP_SLEEP    = 2;
    localparam int OP_TX_PATH_STANDBY   = 1;
    localparam int OP_SHDN     = 0;

    // pll_and_input_setup field positions
    localparam int CFG_PLL_EN  = 15;
    localparam int CFG_LEVEL   = 12;
    localparam int CFG_DIV2    = 11;
    localparam int CFG_EXT_VCO = 10;
    localparam int CFG_PUMP_HI = 9;
    localparam int CFG_PUMP_LO = 8;
    localparam int CFG_POL     = 5;
    localparam int CFG_LOCK    = 0;

    localparam logic [1:0] BAND_FM   = 2'h0;
    localparam logic [1:0] BAND_CELL = 2'h1;
    localparam logic [1:0] BAND_PCS  = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_FRAME = 3'h2,
        ST_LOAD  = 3'h4
    } txmc_state_e;

    // slow pins entering the system clock: {cs_n, tx_gate_n, pll_lock}
    typedef struct packed {
        logic cs_n;
        logic tx_gate_n;
        logic pll_lock;
    } txmc_pins_s;

    localparam txmc_pins_s PINS_IDLE = 3'h6;

    typedef struct packed {
        logic       low_band_lo_input_en;
        logic       high_band_lo_input_en;
        logic       pump_boost_hold;
        logic       fm_mode;
        logic       cellular_pa_output_en;
        logic       pcs_pa_output_en;
        logic [2:0] if_gain_step;
        logic       upper_sideband;
        logic       intermediate_lo_port_en;
        logic       quad_mod_en;
        logic       core_sleep;
        logic       modulator_off;
        logic       chip_shutdown;
        logic       if_pll_off;
        logic       baseband_200mv;
        logic       lo_divide_by_two;
        logic       external_vco_select;
        logic [1:0] pump_current_code;
        logic       detector_positive;
        logic       lock_pin;
    } txmc_ctl_s;

endpackage

/* core/txmc_pin_sync.sv */
/*
 * Three-stage synchroniser for the slow pins into the system clock.
 * A pin change is taken once the second and third stages agree.
 */
module txmc_pin_sync (
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    input  wire txmc_pkg::txmc_pins_s pins_raw,
    output txmc_pkg::txmc_pins_s      pins_clean
);

    typedef struct packed {
        txmc_pkg::txmc_pins_s s1;
        txmc_pkg::txmc_pins_s s2;
        txmc_pkg::txmc_pins_s s3;
        txmc_pkg::txmc_pins_s clean;
    } txmc_sync_s;

    txmc_sync_s st;
    txmc_sync_s next_st;
    logic [2:0] agree;

    always_comb begin
        next_st    = st;
        next_st.s1 = pins_raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // s1 feeds only s2; filtering looks at s2 and s3 alone
        agree         = ~(st.s2 ^ st.s3);
        next_st.clean = (agree & st.s2) | (~agree & st.clean);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= {4{txmc_pkg::PINS_IDLE}};
        end else begin
            st <= next_st;
        end
    end

    assign pins_clean = st.clean;

endmodule

/* core/txmc_link_shift.sv */
/*
 * Serial shift register on the link clock.
 * Assumes the link clock only runs while chip-select is low; no reset here,
 * since the clock may stand still and the word is only read after a frame.
 */
module txmc_link_shift (
    input  wire logic                            sclk,
    input  wire logic                            cs_n,
    input  wire logic                            sdata,
    output logic [txmc_pkg::FRAME_BITS-1:0]      frame
);

    typedef struct packed {
        logic [txmc_pkg::FRAME_BITS-1:0] sr;
    } txmc_link_s;

    txmc_link_s st;
    txmc_link_s next_st;

    always_comb begin
        next_st = st;
        if (!cs_n) begin
            next_st.sr = {st.sr[txmc_pkg::FRAME_BITS-2:0], sdata};
        end
    end

    always_ff @(posedge sclk) begin
        st <= next_st;
    end

    assign frame = st.sr;

endmodule

/* core/txmc_regs.sv */
/*
 * Transmitter mode-control register bank: serial frame capture on the link
 * clock, load on chip-select release, two control registers and the decoded
 * mode, power-down and PLL controls they drive.
 * Assumes the host holds the link clock still while chip-select is high.
 */
// Operation
// - bit 15 routes low-band LO when 1, high-band LO when 0; default 1.
// - bit 13 holds charge pump in high-current mode after lock; default 0.
// - bits 12:11 band: 00 FM, 01 cellular PA, 11 PCS PA; default 01.
// - bits 8:6 give IF gain code, about 2dB per step; default 100.
// - bit 5 picks upper sideband when 1, lower when 0; default 1.
// - bit 4 turns intermediate LO buffer on; default 0.
// - bit 3 selects quadrature modulation, else external VCO modulation; default 1.
// - bit 2 low sleeps everything but registers and serial port; default 1.
// - bit 1 low turns off modulator and upconverter, like gating pin.
// - bit 0 low shuts everything and restores all power-up values.
// - config bit 15 low shuts the internal IF PLL; default 1.
// - config bit 12 selects 200mV baseband level, else 100mV; default 1.
// - config bit 11 adds divide-by-two on intermediate LO; default 0.
// - config bit 10 bypasses internal VCO for external input; default 0.
// - config bits 9:8 set pump current 200/260/400/530uA; default 00.
// - config bit 5 gives positive phase-detector polarity when 1; default 1.
// - config bit 0 high puts PLL lock on lock pin; 0 is test.
// - frame is 24 bits: 20 data msb first then 4 address bits.
// - shift on rising clock while select low; load on select rise.
// - address 0100 operation register, 0101 configuration register, low 16 bits.
module txmc_regs (
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    input  wire logic                 sclk,
    input  wire logic                 cs_n,
    input  wire logic                 sdata,
    input  wire logic                 tx_gating_pin_n,
    input  wire logic                 pll_lock,
    output logic [15:0]               operation_control,
    output logic [15:0]               pll_and_input_setup,
    output txmc_pkg::txmc_ctl_s       ctl
);

    typedef struct packed {
        txmc_pkg::txmc_state_e st;
        logic [15:0]           op;
        logic [15:0]           cfg;
        logic                  shut_hold;
        txmc_pkg::txmc_ctl_s   ctl;
    } txmc_regs_s;

    txmc_regs_s                         st;
    txmc_regs_s                         next_st;
    txmc_pkg::txmc_pins_s               pins_raw;
    txmc_pkg::txmc_pins_s               pins;
    logic [txmc_pkg::FRAME_BITS-1:0]    frame;
    logic [txmc_pkg::REG_BITS-1:0]      frame_data;
    logic [txmc_pkg::ADDR_BITS-1:0]     frame_addr;
    logic                               load_op;
    logic                               load_cfg;

    function automatic txmc_pkg::txmc_ctl_s decode(
        input logic [15:0] op,
        input logic [15:0] cfg,
        input logic        shut,
        input logic        gate_n,
        input logic        lock
    );
        txmc_pkg::txmc_ctl_s c;
        logic [1:0]          band;
        logic                down;
        c    = '0;
        band = op[txmc_pkg::OP_BAND_HI:txmc_pkg::OP_BAND_LO];
        down            = shut | ~op[txmc_pkg::OP_SLEEP];
        c.core_sleep    = down;
        c.chip_shutdown = shut;
        c.modulator_off = down | ~op[txmc_pkg::OP_TX_PATH_STANDBY] | ~gate_n;
        c.low_band_lo_input_en  = op[txmc_pkg::OP_LO_PORT_SELECT];
        c.high_band_lo_input_en = ~op[txmc_pkg::OP_LO_PORT_SELECT];
        c.pump_boost_hold = op[txmc_pkg::OP_BOOST];
        // band mode, code 10 drives no output
        c.fm_mode               = (band == txmc_pkg::BAND_FM);
        c.cellular_pa_output_en = (band == txmc_pkg::BAND_CELL) & ~c.modulator_off;
        c.pcs_pa_output_en      = (band == txmc_pkg::BAND_PCS) & ~c.modulator_off;
        c.if_gain_step = op[txmc_pkg::OP_GAIN_HI:txmc_pkg::OP_GAIN_LO];
        c.upper_sideband = op[txmc_pkg::OP_SIDEBAND];
        c.intermediate_lo_port_en = op[txmc_pkg::OP_BUF] & ~down;
        c.quad_mod_en = op[txmc_pkg::OP_MOD];
        c.if_pll_off = down | ~cfg[txmc_pkg::CFG_PLL_EN];
        c.baseband_200mv = cfg[txmc_pkg::CFG_LEVEL];
        c.lo_divide_by_two = cfg[txmc_pkg::CFG_DIV2];
        c.external_vco_select = cfg[txmc_pkg::CFG_EXT_VCO];
        c.pump_current_code = cfg[txmc_pkg::CFG_PUMP_HI:txmc_pkg::CFG_PUMP_LO];
        c.detector_positive = cfg[txmc_pkg::CFG_POL];
        // lock pin function, test mode held low
        c.lock_pin = cfg[txmc_pkg::CFG_LOCK] & lock & ~c.if_pll_off;
        return c;
    endfunction

    txmc_link_shift u_link (
        .sclk  (sclk),
        .cs_n  (cs_n),
        .sdata (sdata),
        .frame (frame)
    );

    assign pins_raw.cs_n      = cs_n;
    assign pins_raw.tx_gate_n = tx_gating_pin_n;
    assign pins_raw.pll_lock  = pll_lock;

    txmc_pin_sync u_sync (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .pins_raw   (pins_raw),
        .pins_clean (pins)
    );

    // bits above the register width dropped
    assign frame_data = frame[txmc_pkg::DATA_LSB +: txmc_pkg::REG_BITS];
    assign frame_addr = frame[txmc_pkg::ADDR_LSB +: txmc_pkg::ADDR_BITS];

    always_comb begin
        load_op  = 1'b0;
        load_cfg = 1'b0;
        if (st.st != txmc_pkg::ST_LOAD) begin
            load_op  = 1'b0;
        end else if (frame_addr == txmc_pkg::ADDR_OP) begin
            load_op  = 1'b1;
        end else if (frame_addr == txmc_pkg::ADDR_CFG) begin
            load_cfg = 1'b1;
        end
    end

    always_comb begin
        next_st = st;
        case (st.st)
            txmc_pkg::ST_IDLE: begin
                if (!pins.cs_n) begin
                    next_st.st = txmc_pkg::ST_FRAME;
                end
            end
            txmc_pkg::ST_FRAME: begin
                if (pins.cs_n) begin
                    next_st.st = txmc_pkg::ST_LOAD;
                end
            end
            txmc_pkg::ST_LOAD: begin
                // the shift word is quiet here: link clock idles with select high
                next_st.st = txmc_pkg::ST_IDLE;
            end
            default: begin
                next_st.st = txmc_pkg::ST_IDLE;
            end
        endcase
        if (load_op) begin
            next_st.op        = frame_data;
            next_st.shut_hold = ~frame_data[txmc_pkg::OP_SHDN];
        end else if (load_cfg) begin
            next_st.cfg = frame_data;
        end
        // soft shutdown restores defaults until an operation write with bit 0 high lifts it
        if (next_st.shut_hold) begin
            next_st.op  = txmc_pkg::OP_RESET;
            next_st.cfg = txmc_pkg::CFG_RESET;
        end
        next_st.ctl = decode(next_st.op, next_st.cfg, next_st.shut_hold,
                             pins.tx_gate_n, pins.pll_lock);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st.st        <= txmc_pkg::ST_IDLE;
            st.op        <= txmc_pkg::OP_RESET;
            st.cfg       <= txmc_pkg::CFG_RESET;
            st.shut_hold <= 1'b0;
            st.ctl       <= decode(txmc_pkg::OP_RESET, txmc_pkg::CFG_RESET,
                                   1'b0, 1'b1, 1'b0);
        end else begin
            st <= next_st;
        end
    end

    assign operation_control   = st.op;
    assign pll_and_input_setup = st.cfg;
    assign ctl                 = st.ctl;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    a_op_load_value: assert property (
        (load_op && frame_data[txmc_pkg::OP_SHDN]) |=> (st.op == $past(frame_data))
    ) else $error("operation register did not take frame data");

    a_cfg_load_value: assert property (
        (load_cfg && !st.shut_hold) |=> (st.cfg == $past(frame_data))
    ) else $error("configuration register did not take frame data");

    a_other_addr_ignored: assert property (
        (st.st == txmc_pkg::ST_LOAD && !load_op && !load_cfg)
            |=> ($stable(st.op) && $stable(st.cfg))
    ) else $error("unmatched address changed a register");

    a_soft_reset_defaults: assert property (
        (load_op && !frame_data[txmc_pkg::OP_SHDN])
            |=> (st.op == txmc_pkg::OP_RESET && st.cfg == txmc_pkg::CFG_RESET
                 && st.ctl.chip_shutdown)[*3]
    ) else $error("soft shutdown did not restore power-up values");

    a_frame_load_seq: assert property (
        (st.st == txmc_pkg::ST_FRAME && pins.cs_n)
            |=> (st.st == txmc_pkg::ST_LOAD) ##1 (st.st == txmc_pkg::ST_IDLE)
    ) else $error("select release did not load exactly once");

    a_lo_route_match: assert property (
        (st.ctl.low_band_lo_input_en == st.op[txmc_pkg::OP_LO_PORT_SELECT])
            && (st.ctl.high_band_lo_input_en == !st.op[txmc_pkg::OP_LO_PORT_SELECT])
    ) else $error("lo port routing disagrees with register");

    a_band_pa_select: assert property (
        st.ctl.pcs_pa_output_en
            |-> (st.op[txmc_pkg::OP_BAND_HI:txmc_pkg::OP_BAND_LO] == txmc_pkg::BAND_PCS
                 && !st.ctl.cellular_pa_output_en)
    ) else $error("pcs output enabled outside pcs band");

    a_gain_code_match: assert property (
        st.ctl.if_gain_step == st.op[txmc_pkg::OP_GAIN_HI:txmc_pkg::OP_GAIN_LO]
    ) else $error("if gain code disagrees with register");

    a_tx_standby_off: assert property (
        (!next_st.op[txmc_pkg::OP_TX_PATH_STANDBY] || !pins.tx_gate_n) |=> st.ctl.modulator_off
    ) else $error("modulator left on in transmit standby");

    a_sleep_keeps_regs: assert property (
        (!st.op[txmc_pkg::OP_SLEEP] && st.st != txmc_pkg::ST_LOAD)
            |=> ($stable(st.op) && st.ctl.core_sleep)
    ) else $error("sleep lost register contents or stayed awake");

    a_pll_disable_off: assert property (
        !st.cfg[txmc_pkg::CFG_PLL_EN] |-> st.ctl.if_pll_off
    ) else $error("internal pll left running when disabled");

    a_lock_test_low: assert property (
        !st.cfg[txmc_pkg::CFG_LOCK] |-> !st.ctl.lock_pin
    ) else $error("lock pin driven in test mode");

    a_boost_hold_match: assert property (
        st.ctl.pump_boost_hold == st.op[txmc_pkg::OP_BOOST]
    ) else $error("pump boost hold disagrees with register");

    a_fm_mode_match: assert property (
        st.ctl.fm_mode
            == (st.op[txmc_pkg::OP_BAND_HI:txmc_pkg::OP_BAND_LO] == txmc_pkg::BAND_FM)
    ) else $error("fm mode disagrees with band code");

    a_cell_pa_select: assert property (
        st.ctl.cellular_pa_output_en
            |-> (st.op[txmc_pkg::OP_BAND_HI:txmc_pkg::OP_BAND_LO] == txmc_pkg::BAND_CELL
                 && !st.ctl.pcs_pa_output_en)
    ) else $error("cellular output enabled outside cellular band");

    a_sideband_match: assert property (
        st.ctl.upper_sideband == st.op[txmc_pkg::OP_SIDEBAND]
    ) else $error("sideband choice disagrees with register");

    a_lo_buffer_gate: assert property (
        st.ctl.intermediate_lo_port_en
            == (st.op[txmc_pkg::OP_BUF] && !st.ctl.core_sleep)
    ) else $error("lo buffer enable disagrees with register");

    a_mod_select_match: assert property (
        st.ctl.quad_mod_en == st.op[txmc_pkg::OP_MOD]
    ) else $error("modulation select disagrees with register");

    a_sleep_core_off: assert property (
        !st.op[txmc_pkg::OP_SLEEP]
            |-> (st.ctl.core_sleep && st.ctl.if_pll_off && !st.ctl.intermediate_lo_port_en)
    ) else $error("sleep left a function running");

    a_shutdown_all_off: assert property (
        st.ctl.chip_shutdown
            |-> (st.ctl.core_sleep && st.ctl.modulator_off && st.ctl.if_pll_off)
    ) else $error("soft shutdown left a function running");

    a_shut_hold_defaults: assert property (
        st.shut_hold |-> (st.op == txmc_pkg::OP_RESET && st.cfg == txmc_pkg::CFG_RESET)
    ) else $error("registers left power-up values during shutdown");

    a_level_match: assert property (
        st.ctl.baseband_200mv == st.cfg[txmc_pkg::CFG_LEVEL]
    ) else $error("baseband level disagrees with register");

    a_divider_match: assert property (
        st.ctl.lo_divide_by_two == st.cfg[txmc_pkg::CFG_DIV2]
    ) else $error("lo divider disagrees with register");

    a_ext_vco_match: assert property (
        st.ctl.external_vco_select == st.cfg[txmc_pkg::CFG_EXT_VCO]
    ) else $error("external vco select disagrees with register");

    a_pump_code_match: assert property (
        st.ctl.pump_current_code == st.cfg[txmc_pkg::CFG_PUMP_HI:txmc_pkg::CFG_PUMP_LO]
    ) else $error("pump current code disagrees with register");

    a_polarity_match: assert property (
        st.ctl.detector_positive == st.cfg[txmc_pkg::CFG_POL]
    ) else $error("detector polarity disagrees with register");

    a_lock_pin_gate: assert property (
        st.ctl.lock_pin |-> (st.cfg[txmc_pkg::CFG_LOCK] && !st.ctl.if_pll_off)
    ) else $error("lock pin high without lock function");

    a_idle_waits_select: assert property (
        (st.st == txmc_pkg::ST_IDLE && pins.cs_n) |=> (st.st == txmc_pkg::ST_IDLE)
    ) else $error("frame started with select high");

    a_frame_holds_low: assert property (
        (st.st == txmc_pkg::ST_FRAME && !pins.cs_n) |=> (st.st == txmc_pkg::ST_FRAME)
    ) else $error("frame left while select low");

    a_op_addr_load: assert property (
        (st.st == txmc_pkg::ST_LOAD && frame_addr == txmc_pkg::ADDR_OP) |-> load_op
    ) else $error("operation address did not load");

    a_cfg_addr_load: assert property (
        (st.st == txmc_pkg::ST_LOAD && frame_addr == txmc_pkg::ADDR_CFG) |-> load_cfg
    ) else $error("configuration address did not load");

    c_op_write: cover property (load_op && frame_data[txmc_pkg::OP_SHDN]);
    c_cfg_write: cover property (load_cfg);
    c_soft_shutdown: cover property (load_op && !frame_data[txmc_pkg::OP_SHDN]);
    c_unmatched_addr: cover property (st.st == txmc_pkg::ST_LOAD && !load_op && !load_cfg);
    c_gate_pin_low: cover property (!pins.tx_gate_n && st.ctl.modulator_off);

endmodule

/* verification/txmc_host.sv */
/*
 * Host model for the serial link: sends 24-bit write frames.
 * Assumes the bench calls write_frame; the link clock idles low outside frames.
 */
module txmc_host (
    input  wire logic clk_sys,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk  = 1'b0;
        cs_n  = 1'b1;
        sdata = 1'b0;
    end

    task automatic write_frame(input logic [19:0] data, input logic [3:0] addr);
        logic [19:0] d;
        logic [23:0] word;
        d = data;
        if (addr == txmc_pkg::ADDR_OP) begin
            d = d & ~20'h04600;
        end
        if (addr == txmc_pkg::ADDR_CFG) begin
            d = (d & ~20'h060DE) | 20'h0001C;
        end
        // lock bit passed as commanded, test mode only on purpose
        word = {d, addr};
        @(negedge clk_sys);
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            #7 sdata = word[i];
            #8 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
        // no pull on the data line, so show the inverse once released
        #7 sdata = ~word[0];
        @(negedge clk_sys);
        cs_n = 1'b1;
        // covers the slowest load and the minimum high time
        repeat (10) @(negedge clk_sys);
    endtask
endmodule

/* verification/txmc_regs_test.sv */
/*
 * Self-checking bench for the mode-control register bank.
 * Assumes the host model drives the link and waits out each load.
 */
module txmc_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk_sys;
    logic                srst;
    logic                sclk;
    logic                cs_n;
    logic                sdata;
    logic                tx_gating_pin_n;
    logic                pll_lock;
    logic [15:0]         operation_control;
    logic [15:0]         pll_and_input_setup;
    txmc_pkg::txmc_ctl_s ctl;
    logic [15:0]         v;
    logic [15:0]         g;
    int                  fails;
    int                  n_checks;

    txmc_regs u_txmc_regs (
        .clk_sys             (clk_sys),
        .srst                (srst),
        .sclk                (sclk),
        .cs_n                (cs_n),
        .sdata               (sdata),
        .tx_gating_pin_n     (tx_gating_pin_n),
        .pll_lock            (pll_lock),
        .operation_control   (operation_control),
        .pll_and_input_setup (pll_and_input_setup),
        .ctl                 (ctl)
    );

    txmc_host u_txmc_host (
        .clk_sys (clk_sys),
        .sclk    (sclk),
        .cs_n    (cs_n),
        .sdata   (sdata)
    );

    always #5 clk_sys = ~clk_sys;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // upper data nibble always A (1010), it must be dropped
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        u_txmc_host.write_frame({4'hA, d}, a);
    endtask

    task automatic pins(input logic gate_n, input logic lock);
        @(negedge clk_sys);
        tx_gating_pin_n = gate_n;
        pll_lock        = lock;
        repeat (8) @(negedge clk_sys);
    endtask

    task automatic end_sim();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #100us;
        fails++;
        end_sim();
    end

    initial begin
        clk_sys         = 1'b0;
        srst            = 1'b1;
        tx_gating_pin_n = 1'b1;
        pll_lock        = 1'b0;
        fails           = 0;
        n_checks        = 0;
        repeat (6) @(negedge clk_sys);
        srst = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(operation_control, txmc_pkg::OP_RESET);
        chk(pll_and_input_setup, txmc_pkg::CFG_RESET);
        chk(16'({ctl.low_band_lo_input_en, ctl.pump_boost_hold}), 16'h0002);
        chk(16'(ctl.if_gain_step), 16'h0004);
        chk(16'({ctl.upper_sideband, ctl.intermediate_lo_port_en}), 16'h0002);
        chk(16'({ctl.quad_mod_en, ctl.core_sleep, ctl.modulator_off}), 16'h0004);
        chk(16'({ctl.chip_shutdown, ctl.if_pll_off}), 16'h0000);
        chk(16'({ctl.baseband_200mv, ctl.lo_divide_by_two}), 16'h0002);
        chk(16'({ctl.external_vco_select, ctl.detector_positive}), 16'h0001);
        g = 16'({ctl.fm_mode, ctl.cellular_pa_output_en, ctl.pcs_pa_output_en});
        chk(g, 16'h0002);
        // every band code, including the unused one
        for (int b = 0; b < 4; b++) begin
            v = 16'h810F | 16'(b << 11);
            wr(txmc_pkg::ADDR_OP, v);
            chk(operation_control, v);
            g = 16'({ctl.fm_mode, ctl.cellular_pa_output_en, ctl.pcs_pa_output_en});
            chk(g, 16'({b == 0, b == 1, b == 3}));
        end
        wr(txmc_pkg::ADDR_OP, 16'h3957);
        chk(operation_control, 16'h3957);
        chk(16'({ctl.low_band_lo_input_en, ctl.high_band_lo_input_en}), 16'h0001);
        chk(16'({ctl.pump_boost_hold, ctl.if_gain_step}), 16'h000D);
        chk(16'({ctl.upper_sideband, ctl.intermediate_lo_port_en}), 16'h0001);
        chk(16'(ctl.quad_mod_en), 16'h0000);
        for (int c = 0; c < 4; c++) begin
            v = 16'h903D | 16'(c << 8);
            wr(txmc_pkg::ADDR_CFG, v);
            chk(pll_and_input_setup, v);
            chk(16'(ctl.pump_current_code), 16'(c));
        end
        wr(txmc_pkg::ADDR_CFG, 16'h8C1D);
        chk(16'({ctl.baseband_200mv, ctl.lo_divide_by_two}), 16'h0001);
        chk(16'({ctl.external_vco_select, ctl.detector_positive}), 16'h0002);
        pins(1'b1, 1'b1);
        chk(16'(ctl.lock_pin), 16'h0001);
        wr(txmc_pkg::ADDR_CFG, 16'h8C1C);
        chk(16'(ctl.lock_pin), 16'h0000);
        wr(txmc_pkg::ADDR_CFG, 16'h0C1D);
        chk(16'({ctl.if_pll_off, ctl.lock_pin}), 16'h0002);
        wr(txmc_pkg::ADDR_CFG, 16'h8C1D);
        // addresses 0, 3, 6, 9, 12 and 15 must not disturb either register
        for (int a = 0; a < 16; a++) begin
            if (a != 4 && a != 5 && a % 3 == 0) begin
                wr(4'(a), 16'hFFFF);
                chk(operation_control, 16'h3957);
                chk(pll_and_input_setup, 16'h8C1D);
            end
        end
        wr(txmc_pkg::ADDR_OP, 16'h899B);
        chk(operation_control, 16'h899B);
        chk(16'({ctl.core_sleep, ctl.modulator_off, ctl.if_pll_off}), 16'h0007);
        chk(16'(ctl.intermediate_lo_port_en), 16'h0000);
        wr(txmc_pkg::ADDR_OP, 16'h890D);
        chk(16'({ctl.core_sleep, ctl.modulator_off, ctl.cellular_pa_output_en}), 16'h2);
        wr(txmc_pkg::ADDR_OP, 16'h890F);
        chk(16'({ctl.modulator_off, ctl.cellular_pa_output_en}), 16'h0001);
        pins(1'b0, 1'b1);
        chk(16'({ctl.modulator_off, ctl.cellular_pa_output_en}), 16'h0002);
        pins(1'b1, 1'b1);
        chk(16'({ctl.modulator_off, ctl.cellular_pa_output_en}), 16'h0001);
        wr(txmc_pkg::ADDR_OP, 16'h890E);
        chk(operation_control, txmc_pkg::OP_RESET);
        chk(pll_and_input_setup, txmc_pkg::CFG_RESET);
        chk(16'({ctl.chip_shutdown, ctl.core_sleep}), 16'h0003);
        // config writes are lost while shut down
        wr(txmc_pkg::ADDR_CFG, 16'h8C1D);
        chk(pll_and_input_setup, txmc_pkg::CFG_RESET);
        wr(txmc_pkg::ADDR_OP, 16'h890F);
        chk(operation_control, 16'h890F);
        chk(16'({ctl.chip_shutdown, ctl.core_sleep}), 16'h0000);
        end_sim();
    end
endmodule
